// *** verilog/gpioc_port.sv ***
// GPIO port: register file, AXI4-Lite slave and pad control
//
// Summary of operation
// - Neighbour negative drive register, resets zero
// - Current drive needs pin bit and global
// - Direction one makes pin tri-stated input
// - Direction zero drives latch onto pin
// - Port read pins, write goes latch
// - Port write replaces the whole latch byte
// - Latch holds most recent latch/port write
// - Direction controls drivers despite analog select
// - Analog selected pins read as zero
// - Analog select leaves digital output alone
// - Level select picks Schmitt or TTL
// - Open-drain bit makes output sink only
// - I2C ownership forces open-drain
// - Slew bit limits output slew rate
// - Independent weak pull-up bit per pin
// - Reset output source is port latch
// - Pull-up on, auto off for outputs
// - Direction bits reset to one
`timescale 1ns/10ps
module gpioc_port
   import gpioc_pkg::*;
(
   input  wire logic                    CLK_SYS,
   input  wire logic                    NRST,
   input  wire logic [GPIOC_ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                    S_AXI_AWVALID,
   output logic                         S_AXI_AWREADY,
   input  wire logic [31:0]             S_AXI_WDATA,
   input  wire logic [3:0]              S_AXI_WSTRB,
   input  wire logic                    S_AXI_WVALID,
   output logic                         S_AXI_WREADY,
   output logic [1:0]                   S_AXI_BRESP,
   output logic                         S_AXI_BVALID,
   input  wire logic                    S_AXI_BREADY,
   input  wire logic [GPIOC_ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic                    S_AXI_ARVALID,
   output logic                         S_AXI_ARREADY,
   output logic [31:0]                  S_AXI_RDATA,
   output logic [1:0]                   S_AXI_RRESP,
   output logic                         S_AXI_RVALID,
   input  wire logic                    S_AXI_RREADY,
   input  wire logic [7:0]              PIN_SCHMITT_IN,
   input  wire logic [7:0]              PIN_TTL_IN,
   input  wire logic [7:0]              I2C_OWN,
   output gpioc_pad_s                   PAD_CTRL,
   output logic [7:0]                   NEG_DRIVE_B
);

   logic [7:0]  dir_reg;
   logic [7:0]  lat_reg;
   logic [7:0]  ansel_reg;
   logic [7:0]  wpu_reg;
   logic [7:0]  odc_reg;
   logic [7:0]  slr_reg;
   logic [7:0]  inlvl_reg;
   logic [7:0]  ccdp_reg;
   logic [7:0]  ccdn_reg;
   logic [7:0]  cdctl_reg;
   logic [7:0]  negb_reg;
   logic [7:0]  s_sync1_reg;
   logic [7:0]  s_sync2_reg;
   logic [7:0]  t_sync1_reg;
   logic [7:0]  t_sync2_reg;
   logic [7:0]  i_sync1_reg;
   logic [7:0]  i_sync2_reg;
   logic [7:0]  pin_level;
   logic [7:0]  pin_read;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [5:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        wr_fire;
   logic        wr_lane0;
   logic        rd_fire;
   logic [5:0]  wr_addr;
   logic [7:0]  wr_byte;
   logic        ccd_global;

   // Decodes an offset into a known-register flag
   function automatic logic gpioc_mapped(input logic [5:0] a);
      gpioc_mapped = (a[1:0] == 2'b00) && (a <= GPIOC_OFF_NEGB);
   endfunction

   // Pin samples pass two flops before any read logic
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         s_sync1_reg <= GPIOC_RST_ZERO;
         s_sync2_reg <= GPIOC_RST_ZERO;
         t_sync1_reg <= GPIOC_RST_ZERO;
         t_sync2_reg <= GPIOC_RST_ZERO;
         i_sync1_reg <= GPIOC_RST_ZERO;
         i_sync2_reg <= GPIOC_RST_ZERO;
      end else begin
         s_sync1_reg <= PIN_SCHMITT_IN;
         s_sync2_reg <= s_sync1_reg;
         t_sync1_reg <= PIN_TTL_IN;
         t_sync2_reg <= t_sync1_reg;
         i_sync1_reg <= I2C_OWN;
         i_sync2_reg <= i_sync1_reg;
      end
   end

   // Threshold choice picks the sample that port reads return
   assign pin_level = (inlvl_reg & s_sync2_reg)
                    | (~inlvl_reg & t_sync2_reg);
   assign pin_read  = pin_level & ~ansel_reg;

   // Write channel: address and data taken in either order
   assign wr_fire  = aw_held_reg && w_held_reg && !S_AXI_BVALID;
   assign wr_addr  = awaddr_reg;
   assign wr_byte  = wdata_reg[7:0];
   assign wr_lane0 = wr_fire && wstrb_reg[0] && gpioc_mapped(wr_addr);

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         awaddr_reg    <= 6'h00;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= GPIOC_RESP_OKAY;
      end else begin
         S_AXI_AWREADY <= !aw_held_reg && !S_AXI_AWREADY;
         S_AXI_WREADY  <= !w_held_reg && !S_AXI_WREADY;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held_reg   <= 1'b1;
            awaddr_reg    <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held_reg   <= 1'b1;
            wdata_reg    <= S_AXI_WDATA;
            wstrb_reg    <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
         end
         if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= gpioc_mapped(wr_addr) ? GPIOC_RESP_OKAY
                                                  : GPIOC_RESP_SLVERR;
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
         end
      end
   end

   // Direction and analog select reset to tri-stated analog inputs
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         dir_reg   <= GPIOC_RST_DIR;
         ansel_reg <= GPIOC_RST_ANSEL;
      end else if (wr_lane0) begin
         if (wr_addr == GPIOC_OFF_DIR) begin
            dir_reg <= wr_byte;
         end
         if (wr_addr == GPIOC_OFF_ANSEL) begin
            ansel_reg <= wr_byte;
         end
      end
   end

   // Port writes land in the latch as a whole byte
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         lat_reg <= GPIOC_RST_ZERO;
      end else if (wr_lane0) begin
         if (wr_addr == GPIOC_OFF_LAT) begin
            lat_reg <= wr_byte;
         end
         if (wr_addr == GPIOC_OFF_PORT) begin
            lat_reg <= wr_byte;
         end
      end
   end

   // Pad option registers
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         wpu_reg   <= GPIOC_RST_ZERO;
         odc_reg   <= GPIOC_RST_ZERO;
         slr_reg   <= GPIOC_RST_SLR;
         inlvl_reg <= GPIOC_RST_INLVL;
      end else if (wr_lane0) begin
         case (wr_addr)
            GPIOC_OFF_WPU:   wpu_reg   <= wr_byte;
            GPIOC_OFF_ODC:   odc_reg   <= wr_byte;
            GPIOC_OFF_SLR:   slr_reg   <= wr_byte;
            GPIOC_OFF_INLVL: inlvl_reg <= wr_byte;
            default: begin
            end
         endcase
      end
   end

   // Current-drive registers
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         ccdp_reg   <= GPIOC_RST_ZERO;
         ccdn_reg   <= GPIOC_RST_ZERO;
         cdctl_reg  <= GPIOC_RST_ZERO;
         negb_reg   <= GPIOC_RST_ZERO;
      end else if (wr_lane0) begin
         case (wr_addr)
            GPIOC_OFF_CCDP:   ccdp_reg   <= wr_byte;
            GPIOC_OFF_CCDN:   ccdn_reg   <= wr_byte;
            GPIOC_OFF_CDCTL:  cdctl_reg  <= wr_byte & GPIOC_CDCTL_MASK;
            GPIOC_OFF_NEGB:   negb_reg   <= wr_byte;
            default: begin
            end
         endcase
      end
   end

   // Read channel: one read in flight, data returned a cycle later
   assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= GPIOC_RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
         if (rd_fire) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RRESP   <= gpioc_mapped(S_AXI_ARADDR) ? GPIOC_RESP_OKAY
                                                        : GPIOC_RESP_SLVERR;
            case (S_AXI_ARADDR)
               GPIOC_OFF_PORT:   S_AXI_RDATA <= {24'h00_0000, pin_read};
               GPIOC_OFF_DIR:    S_AXI_RDATA <= {24'h00_0000, dir_reg};
               GPIOC_OFF_LAT:    S_AXI_RDATA <= {24'h00_0000, lat_reg};
               GPIOC_OFF_ANSEL:  S_AXI_RDATA <= {24'h00_0000, ansel_reg};
               GPIOC_OFF_WPU:    S_AXI_RDATA <= {24'h00_0000, wpu_reg};
               GPIOC_OFF_ODC:    S_AXI_RDATA <= {24'h00_0000, odc_reg};
               GPIOC_OFF_SLR:    S_AXI_RDATA <= {24'h00_0000, slr_reg};
               GPIOC_OFF_INLVL:  S_AXI_RDATA <= {24'h00_0000, inlvl_reg};
               GPIOC_OFF_CCDP:   S_AXI_RDATA <= {24'h00_0000, ccdp_reg};
               GPIOC_OFF_CCDN:   S_AXI_RDATA <= {24'h00_0000, ccdn_reg};
               GPIOC_OFF_CDCTL:  S_AXI_RDATA <= {24'h00_0000, cdctl_reg};
               GPIOC_OFF_NEGB:   S_AXI_RDATA <= {24'h00_0000, negb_reg};
               default:          S_AXI_RDATA <= 32'h0000_0000;
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // Pad controls registered so every output is a flop
   assign ccd_global = cdctl_reg[GPIOC_CCD_EN_BIT];

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         PAD_CTRL    <= '0;
         NEG_DRIVE_B <= GPIOC_RST_ZERO;
      end else begin
         // Latch is the only output source in this block
         PAD_CTRL.drive_out   <= lat_reg;
         // Analog select deliberately absent from driver enable
         PAD_CTRL.drive_en    <= ~dir_reg;
         PAD_CTRL.open_drain <= odc_reg | i2c_mask(i_sync2_reg);
         PAD_CTRL.slew_limit  <= slr_reg;
         PAD_CTRL.pullup_en   <= wpu_reg & dir_reg;
         PAD_CTRL.schmitt_sel <= inlvl_reg;
         // Undefined with global off; gating keeps pad safe
         PAD_CTRL.ccd_pos     <= ccdp_reg & {8{ccd_global}};
         PAD_CTRL.ccd_neg     <= ccdn_reg & {8{ccd_global}};
         NEG_DRIVE_B          <= negb_reg & {8{ccd_global}};
      end
   end

   // Pins owned by the I2C function
   function automatic logic [7:0] i2c_mask(input logic [7:0] own);
      i2c_mask = own;
   endfunction

endmodule

// *** verilog/gpioc_pkg.sv ***
// Package: register map, reset values and carrier types for the GPIO port
package gpioc_pkg;
   localparam int          GPIOC_ADDR_W        = 6;
   localparam logic [5:0]  GPIOC_OFF_PORT      = 6'h00;
   localparam logic [5:0]  GPIOC_OFF_DIR       = 6'h04;
   localparam logic [5:0]  GPIOC_OFF_LAT       = 6'h08;
   localparam logic [5:0]  GPIOC_OFF_ANSEL     = 6'h0C;
   localparam logic [5:0]  GPIOC_OFF_WPU       = 6'h10;
   localparam logic [5:0]  GPIOC_OFF_ODC       = 6'h14;
   localparam logic [5:0]  GPIOC_OFF_SLR       = 6'h18;
   localparam logic [5:0]  GPIOC_OFF_INLVL     = 6'h1C;
   localparam logic [5:0]  GPIOC_OFF_CCDP      = 6'h20;
   localparam logic [5:0]  GPIOC_OFF_CCDN      = 6'h24;
   localparam logic [5:0]  GPIOC_OFF_CDCTL     = 6'h28;
   localparam logic [5:0]  GPIOC_OFF_NEGB      = 6'h2C;
   localparam logic [7:0]  GPIOC_RST_DIR       = 8'hFF;
   localparam logic [7:0]  GPIOC_RST_ANSEL     = 8'hFF;
   localparam logic [7:0]  GPIOC_RST_ZERO      = 8'h00;
   localparam logic [7:0]  GPIOC_RST_SLR       = 8'hFF;
   localparam logic [7:0]  GPIOC_RST_INLVL     = 8'hFF;
   localparam int          GPIOC_CCD_EN_BIT    = 7;
   localparam logic [7:0]  GPIOC_CDCTL_MASK    = 8'h83;
   localparam logic [1:0]  GPIOC_RESP_OKAY     = 2'b00;
   localparam logic [1:0]  GPIOC_RESP_SLVERR   = 2'b10;

   // Per-pin pad controls, one bit per pin in each field
   typedef struct packed {
      logic [7:0] drive_out;
      logic [7:0] drive_en;
      logic [7:0] open_drain;
      logic [7:0] slew_limit;
      logic [7:0] pullup_en;
      logic [7:0] schmitt_sel;
      logic [7:0] ccd_pos;
      logic [7:0] ccd_neg;
   } gpioc_pad_s;
endpackage

// *** test/gpioc_port_monitor.sv ***
// Checker on the GPIO port pins and register bus
`timescale 1ns/10ps
module gpioc_port_monitor
   import gpioc_pkg::*;
(
   input wire logic        CLK_SYS,
   input wire logic        NRST,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [7:0]  I2C_OWN,
   input wire gpioc_pad_s  PAD_CTRL,
   input wire logic [7:0]  NEG_DRIVE_B
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   // Held address and data fire one cycle, response shows the next
   property p_bvalid;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
         |-> ##2 S_AXI_BVALID;
   endproperty
   a_bvalid: assert property (p_bvalid) else $error("late wr resp");
   property p_rvalid;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("late read data");
   property p_bone;
      S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
   endproperty
   a_bone: assert property (p_bone) else $error("extra write resp");
   property p_rone;
      S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
   endproperty
   a_rone: assert property (p_rone) else $error("extra read data");
   property p_rdhi;
      S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000;
   endproperty
   a_rdhi: assert property (p_rdhi) else $error("upper data set");
   // Pull-up must never fight an enabled driver
   property p_pullup;
      (PAD_CTRL.pullup_en & PAD_CTRL.drive_en) == 8'h00;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pullup on out");
   property p_i2c;
      $stable(I2C_OWN) [*5] |-> (PAD_CTRL.open_drain & I2C_OWN) == I2C_OWN;
   endproperty
   a_i2c: assert property (p_i2c) else $error("i2c not open drain");
   property p_rst;
      $rose(NRST) |=> PAD_CTRL.drive_en == 8'h00
         && PAD_CTRL.slew_limit == 8'hFF && NEG_DRIVE_B == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset pads");
   c_wr: cover property (S_AXI_BVALID && S_AXI_BREADY);
   c_rd: cover property (S_AXI_RVALID && S_AXI_RREADY);
   c_i2c: cover property ((PAD_CTRL.open_drain & I2C_OWN) != 8'h00);
endmodule
bind gpioc_port gpioc_port_monitor gpioc_port_monitor_i (.CLK_SYS, .NRST,
   .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
   .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
   .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .I2C_OWN, .PAD_CTRL,
   .NEG_DRIVE_B);

// *** test/gpioc_pins.sv ***
// Model of the external circuit on the eight port pins
`timescale 1ns/10ps
module gpioc_pins
   import gpioc_pkg::*;
(
   input wire gpioc_pad_s  PAD,
   input wire logic [7:0]  EXT,
   input wire logic [7:0]  TTL_SKEW,
   output logic [7:0]      SCHMITT,
   output logic [7:0]      TTL
);
   logic [7:0] lvl;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         // Open drain only sinks; a high is left to the outside
         lvl[i] = (PAD.drive_en[i] && !(PAD.open_drain[i]
            && PAD.drive_out[i])) ? PAD.drive_out[i] : EXT[i];
      end
   end
   assign SCHMITT = lvl;
   // Mid-rail input: the two buffers disagree where skew is set
   assign TTL = lvl ^ TTL_SKEW;
endmodule

// *** test/gpio_port_pin_control_tb.sv ***
// Self-checking bench for the GPIO port
`timescale 1ns/10ps
module gpio_port_pin_control_tb
   import gpioc_pkg::*;
;
   logic             CLK_SYS, NRST, S_AXI_AWVALID, S_AXI_WVALID;
   logic             S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
   logic             S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
   logic             S_AXI_ARREADY, S_AXI_RVALID;
   logic [5:0]       S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0]      S_AXI_WDATA, S_AXI_RDATA;
   logic [3:0]       S_AXI_WSTRB;
   logic [1:0]       S_AXI_BRESP, S_AXI_RRESP;
   logic [7:0]       PIN_SCHMITT_IN, PIN_TTL_IN, I2C_OWN, NEG_DRIVE_B;
   logic [7:0]       EXT, TTL_SKEW;
   gpioc_pad_s       PAD_CTRL;
   int               n_errors = 0;
   int               samples_checked = 0;
   gpioc_port gpioc_port_i (.CLK_SYS, .NRST, .S_AXI_AWADDR, .S_AXI_AWVALID,
      .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
      .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
      .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
      .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .PIN_SCHMITT_IN,
      .PIN_TTL_IN, .I2C_OWN, .PAD_CTRL, .NEG_DRIVE_B);
   gpioc_pins gpioc_pins_i (.PAD(PAD_CTRL), .EXT, .TTL_SKEW,
      .SCHMITT(PIN_SCHMITT_IN), .TTL(PIN_TTL_IN));
   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end
   task automatic summarize;
      $display("Checked %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge CLK_SYS);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= {24'h00_0000, d};
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge CLK_SYS);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (!S_AXI_BVALID);
      S_AXI_BREADY <= 1'b0;
      chk("bresp", S_AXI_BRESP, (a < 6'h30) ? 2'b00 : 2'b10);
   endtask
   task automatic rc(input string n, input logic [5:0] a, logic [31:0] e);
      @(posedge CLK_SYS);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge CLK_SYS);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (!S_AXI_RVALID);
      S_AXI_RREADY <= 1'b0;
      chk(n, S_AXI_RDATA, e);
      chk("rresp", S_AXI_RRESP, (a < 6'h30) ? 2'b00 : 2'b10);
   endtask
   // Pins cross two sync flops plus the pad register
   task automatic st;
      repeat (5) @(posedge CLK_SYS);
   endtask
   task automatic t_reset;
      logic [95:0] rv = 96'h00FF_00FF_0000_FFFF_0000_0000;
      for (int i = 0; i < 12; i++) begin
         rc("reset", 6'(4 * i), {24'h00_0000, rv[95 - 8 * i -: 8]});
      end
      rc("unmapped", 6'h30, 32'h0000_0000);
      wr(6'h30, 8'hFF);
      chk("tristate", PAD_CTRL.drive_en, 8'h00);
      chk("source", PAD_CTRL.drive_out, 8'h00);
   endtask
   task automatic t_port;
      wr(GPIOC_OFF_ANSEL, 8'h00);
      wr(GPIOC_OFF_DIR, 8'hF0);
      wr(GPIOC_OFF_PORT, 8'hA5);
      rc("latch", GPIOC_OFF_LAT, 32'h0000_00A5);
      wr(GPIOC_OFF_LAT, 8'h3C);
      EXT <= 8'h90;
      st;
      chk("out", PAD_CTRL.drive_out, 8'h3C);
      chk("dir", PAD_CTRL.drive_en, 8'h0F);
      rc("pins", GPIOC_OFF_PORT, 32'h0000_009C);
      wr(GPIOC_OFF_ANSEL, 8'h84);
      st;
      rc("analog", GPIOC_OFF_PORT, 32'h0000_0018);
      chk("anout", PAD_CTRL.drive_out&PAD_CTRL.drive_en, 8'h0C);
   endtask
   task automatic t_level;
      wr(GPIOC_OFF_ANSEL, 8'h00);
      TTL_SKEW <= 8'hFF;
      st;
      rc("st", GPIOC_OFF_PORT, 32'h0000_009C);
      // No peripheral is active while the threshold moves
      wr(GPIOC_OFF_INLVL, 8'h0F);
      st;
      rc("ttl", GPIOC_OFF_PORT, 32'h0000_006C);
      chk("stsel", PAD_CTRL.schmitt_sel, 8'h0F);
   endtask
   task automatic t_pad;
      wr(GPIOC_OFF_WPU, 8'hFF);
      wr(GPIOC_OFF_ODC, 8'h11);
      wr(GPIOC_OFF_SLR, 8'h00);
      I2C_OWN <= 8'h80;
      st;
      chk("pullup", PAD_CTRL.pullup_en, 8'hF0);
      chk("od", PAD_CTRL.open_drain, 8'h91);
      chk("slew", PAD_CTRL.slew_limit, 8'h00);
      // A write with lane 0 off must leave the register alone
      S_AXI_WSTRB <= 4'h0;
      wr(GPIOC_OFF_SLR, 8'hFF);
      S_AXI_WSTRB <= 4'h1;
      rc("strobe", GPIOC_OFF_SLR, 32'h0000_0000);
      // Global enable goes first so pin bits never sit undefined
      wr(GPIOC_OFF_CDCTL, 8'hFF);
      rc("cdctl", GPIOC_OFF_CDCTL, 32'h0000_0083);
      wr(GPIOC_OFF_CCDP, 8'h0F);
      wr(GPIOC_OFF_CCDN, 8'hF0);
      wr(GPIOC_OFF_NEGB, 8'h55);
      st;
      chk("pos", PAD_CTRL.ccd_pos, 8'h0F);
      chk("neg", PAD_CTRL.ccd_neg, 8'hF0);
      chk("negb", NEG_DRIVE_B, 8'h55);
      wr(GPIOC_OFF_CCDP, 8'h00);
      st;
      chk("posoff", PAD_CTRL.ccd_pos, 8'h00);
   endtask
   initial begin
      {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID, S_AXI_BREADY,
         S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY, I2C_OWN, EXT, TTL_SKEW,
         NRST} = '0;
      S_AXI_WSTRB = 4'h1;
      repeat (4) @(posedge CLK_SYS);
      NRST <= 1'b1;
      t_reset;
      t_port;
      t_level;
      t_pad;
      summarize;
   end
   initial begin
      #100_000;
      n_errors++;
      summarize;
   end
endmodule
